// File: core/address_decode.sv
// Effective address former and target steering for one access.
// Assumes all inputs stable while an access request is presented.
`timescale 1ns/1ps
`include "xdata_map_defines.svh"
module address_decode
  import xdata_map_pkg::*;
(
  // Access form and pointers
  input  wire logic        short_form,
  input  wire logic        use_pointer_one,
  input  wire logic        write,
  input  wire logic [15:0] data_pointer_16,
  input  wire logic [7:0]  indirect_pointer_zero,
  input  wire logic [7:0]  indirect_pointer_one,
  input  wire logic [7:0]  external_data_space_page_select,
  // Configuration
  input  wire logic        fifo_window_enable,
  input  wire logic        program_store_write_enable,
  input  wire mem_mode_e   mode,
  input  wire logic        small_ram,
  // Result
  output logic      [15:0] eff_addr,
  output target_e          target
);

  logic in_window;
  logic below_onchip;

  // Address forming and steering
  always_comb begin
    if (short_form) begin
      eff_addr = {external_data_space_page_select,
                  use_pointer_one ? indirect_pointer_one
                                  : indirect_pointer_zero};
    end else begin
      eff_addr = data_pointer_16;
    end
    in_window    = (eff_addr >= `FIFO_WIN_LO) && (eff_addr <= `FIFO_WIN_HI);
    below_onchip = small_ram ? (eff_addr < `ONCHIP_2K_BYTES)
                             : (eff_addr < `ONCHIP_4K_BYTES);
    if (write && program_store_write_enable) begin
      target = target_flash;
    end else if (fifo_window_enable && in_window) begin
      target = target_fifo;
    end else begin
      unique case (mode)
        mode_onchip_only:  target = target_onchip;
        mode_split_nobank,
        mode_split_bank:   target = below_onchip ? target_onchip
                                                 : target_offchip;
        mode_offchip_only: target = target_offchip;
      endcase
    end
  end

endmodule : address_decode

// File: core/xdata_map.sv
// External data address map, on-chip RAM, FIFO window and port claim.
// Assumes the core holds each request until done; the USB domain FIFO
// RAM is reached through a request/acknowledge pair synchronous here.
`timescale 1ns/1ps
`include "xdata_map_defines.svh"
module xdata_map
  import xdata_map_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        enable,
  // Register writes from the core
  input  wire logic        pointer_high_write,
  input  wire logic        pointer_low_write,
  input  wire logic        page_write,
  input  wire logic        config_write,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  indirect_pointer_zero,
  input  wire logic [7:0]  indirect_pointer_one,
  input  wire logic        program_store_write_enable,
  input  wire logic        small_ram,
  // Access request
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        short_form,
  input  wire logic        use_pointer_one,
  input  wire logic [7:0]  wdata,
  // Access answer
  output logic             done,
  output logic      [7:0]  rdata,
  output logic             flash_write,
  output logic      [15:0] flash_addr,
  // FIFO RAM port toward the USB domain
  output logic             fifo_req,
  output logic             fifo_write,
  output logic      [9:0]  fifo_addr,
  output logic      [7:0]  fifo_wdata,
  input  wire logic        fifo_ack,
  input  wire logic [7:0]  fifo_rdata,
  // Off-chip memory port
  input  wire logic [7:0]  port_data_in,
  output logic             port_claim,
  output logic      [15:0] port_addr,
  output logic             port_addr_high_oe,
  output logic      [7:0]  port_data_out,
  output logic             port_data_oe,
  output logic             port_read_strobe_n,
  output logic             port_write_strobe_n,
  output logic             port_addr_latch,
  // Status
  output logic      [15:0] data_pointer_16,
  output logic      [7:0]  external_data_space_page_select,
  output logic      [7:0]  external_memory_config
);

  typedef enum logic [2:0] {
    st_idle, st_ram, st_fifo, st_off_addr, st_off_strobe, st_off_end
  } state_e;

  state_e      state, next_state;
  logic [15:0] next_data_pointer_16;
  logic [7:0]  next_external_data_space_page_select, next_config;
  logic [15:0] eff_addr;
  target_e     target;
  mem_mode_e   mode;
  logic        ram_select;
  logic [7:0]  ram_rdata;
  logic [3:0]  wait_count, next_wait_count;
  logic        next_done, next_flash_write;
  logic [7:0]  next_rdata;
  logic [15:0] next_flash_addr;
  logic        next_fifo_req, next_claim, next_high_oe, next_data_oe;
  logic        next_rd_n, next_wr_n, next_ale;
  logic [15:0] next_port_addr;
  logic [7:0]  next_port_data;

  assign mode = mem_mode_e'(external_memory_config[`CFG_MODE_HI:`CFG_MODE_LO]);

  address_decode u_decode (
    .short_form                 (short_form),
    .use_pointer_one            (use_pointer_one),
    .write                      (req_write),
    .data_pointer_16            (data_pointer_16),
    .indirect_pointer_zero      (indirect_pointer_zero),
    .indirect_pointer_one       (indirect_pointer_one),
    .external_data_space_page_select           (external_data_space_page_select),
    .fifo_window_enable         (external_memory_config[`CFG_FIFO_WIN_BIT]),
    .program_store_write_enable (program_store_write_enable),
    .mode                       (mode),
    .small_ram                  (small_ram),
    .eff_addr                   (eff_addr),
    .target                     (target)
  );

  // On-chip RAM, aliasing inside 2k or 4k
  assign ram_select = enable && (state == st_idle) && req
                      && (target == target_onchip);
  xdata_ram #(.ADDR_W(`ONCHIP_ADDR_W)) u_ram (
    .clock  (clock),
    .enable (enable),
    .select (ram_select),
    .write  (req_write),
    .addr   ({eff_addr[11] & ~small_ram, eff_addr[10:0]}),
    .wdata  (wdata),
    .rdata  (ram_rdata)
  );

  // Register next values
  always_comb begin
    next_data_pointer_16  = data_pointer_16;
    next_external_data_space_page_select = external_data_space_page_select;
    next_config           = external_memory_config;
    if (pointer_high_write) begin
      next_data_pointer_16[15:8] = reg_wdata;
    end
    if (pointer_low_write) begin
      next_data_pointer_16[7:0] = reg_wdata;
    end
    if (page_write) begin
      next_external_data_space_page_select = reg_wdata;
    end
    if (config_write) begin
      next_config = reg_wdata & 8'h5f;
    end
  end

  // Access sequencer next values
  always_comb begin
    next_state       = state;
    next_wait_count  = wait_count;
    next_done        = 1'b0;
    next_rdata       = rdata;
    next_flash_write = 1'b0;
    next_flash_addr  = flash_addr;
    next_fifo_req    = fifo_req;
    next_claim       = port_claim;
    next_high_oe     = port_addr_high_oe;
    next_data_oe     = port_data_oe;
    next_rd_n        = port_read_strobe_n;
    next_wr_n        = port_write_strobe_n;
    next_ale         = port_addr_latch;
    next_port_addr   = port_addr;
    next_port_data   = port_data_out;
    unique case (state)
      st_idle: begin
        if (req) begin
          unique case (target)
            target_flash: begin
              next_flash_write = 1'b1;
              next_flash_addr  = eff_addr;
              next_done        = 1'b1;
              next_state       = st_off_end;
            end
            target_onchip: begin
              next_state = st_ram;
            end
            target_fifo: begin
              next_fifo_req   = 1'b1;
              next_wait_count = `FIFO_WAIT_CYCLES;
              next_state      = st_fifo;
            end
            target_offchip: begin
              next_claim     = 1'b1;
              next_port_addr = eff_addr;
              next_high_oe   = ~(short_form && mode == mode_split_nobank);
              next_ale       = ~external_memory_config[`CFG_MUX_BIT];
              next_port_data = eff_addr[7:0];
              next_data_oe   = ~external_memory_config[`CFG_MUX_BIT];
              next_state     = st_off_addr;
            end
          endcase
        end
      end
      st_ram: begin
        next_rdata = ram_rdata;
        next_done  = 1'b1;
        next_state = st_off_end;
      end
      st_fifo: begin
        if (wait_count != 4'h0) begin
          next_wait_count = wait_count - 4'h1;
        end
        if (fifo_ack && wait_count == 4'h0) begin
          next_fifo_req = 1'b0;
          next_rdata    = fifo_rdata;
          next_done     = 1'b1;
          next_state    = st_off_end;
        end
      end
      st_off_addr: begin
        next_ale       = 1'b0;
        next_port_data = wdata;
        next_data_oe   = req_write;
        next_rd_n      = req_write;
        next_wr_n      = ~req_write;
        next_state     = st_off_strobe;
      end
      st_off_strobe: begin
        next_rdata   = port_data_in;
        next_rd_n    = 1'b1;
        next_wr_n    = 1'b1;
        next_claim   = 1'b0;
        next_high_oe = 1'b0;
        next_data_oe = 1'b0;
        next_done    = 1'b1;
        next_state   = st_off_end;
      end
      st_off_end: begin
        if (!req) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  // Registers; outputs carry no pin mode, which stays with port logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state                  <= st_idle;
      wait_count             <= 4'h0;
      data_pointer_16        <= `POINTER_RESET;
      external_data_space_page_select       <= `PAGE_RESET;
      external_memory_config <= `CFG_RESET;
      done                   <= 1'b0;
      rdata                  <= 8'h00;
      flash_write            <= 1'b0;
      flash_addr             <= 16'h0000;
      fifo_req               <= 1'b0;
      port_claim             <= 1'b0;
      port_addr_high_oe      <= 1'b0;
      port_data_oe           <= 1'b0;
      port_read_strobe_n     <= 1'b1;
      port_write_strobe_n    <= 1'b1;
      port_addr_latch        <= 1'b0;
      port_addr              <= 16'h0000;
      port_data_out          <= 8'h00;
      fifo_write             <= 1'b0;
      fifo_addr              <= 10'h000;
      fifo_wdata             <= 8'h00;
    end else if (enable) begin
      state                  <= next_state;
      wait_count             <= next_wait_count;
      data_pointer_16        <= next_data_pointer_16;
      external_data_space_page_select       <= next_external_data_space_page_select;
      external_memory_config <= next_config;
      done                   <= next_done;
      rdata                  <= next_rdata;
      flash_write            <= next_flash_write;
      flash_addr             <= next_flash_addr;
      fifo_req               <= next_fifo_req;
      port_claim             <= next_claim;
      port_addr_high_oe      <= next_high_oe;
      port_data_oe           <= next_data_oe;
      port_read_strobe_n     <= next_rd_n;
      port_write_strobe_n    <= next_wr_n;
      port_addr_latch        <= next_ale;
      port_addr              <= next_port_addr;
      port_data_out          <= next_port_data;
      if (state == st_idle && req) begin
        fifo_write <= req_write;
        fifo_addr  <= eff_addr[`FIFO_INDEX_W-1:0];
        fifo_wdata <= wdata;
      end
    end
  end

  // Checks
  sequence fifo_start_s;
    state == st_idle && req && target == target_fifo && enable;
  endsequence

  AST_FIFO_SLOW: assert property (@(posedge clock) disable iff (rst)
    fifo_start_s |=> !done [*4])
    else $error("FIFO access answered too early");
  AST_WINDOW_HIDES: assert property (@(posedge clock) disable iff (rst)
    (external_memory_config[`CFG_FIFO_WIN_BIT] && eff_addr >= `FIFO_WIN_LO
     && eff_addr <= `FIFO_WIN_HI && !(req_write && program_store_write_enable))
    |-> target == target_fifo)
    else $error("Window address not steered to FIFO");
  AST_CLAIM_OFFCHIP: assert property (@(posedge clock) disable iff (rst)
    $rose(port_claim) |-> $past(target) == target_offchip)
    else $error("Pins claimed without off-chip access");
  AST_CLAIM_RELEASE: assert property (@(posedge clock) disable iff (rst)
    (port_claim && enable) |-> ##[1:3] !port_claim)
    else $error("Pins held after access");
  AST_READ_NO_DRIVE: assert property (@(posedge clock) disable iff (rst)
    !port_read_strobe_n |-> !port_data_oe)
    else $error("Data driven during read");
  AST_LONG_FORM: assert property (@(posedge clock) disable iff (rst)
    !short_form |-> eff_addr == data_pointer_16)
    else $error("Long form address wrong");
  AST_SHORT_FORM: assert property (@(posedge clock) disable iff (rst)
    short_form |-> eff_addr[15:8] == external_data_space_page_select)
    else $error("Short form page wrong");
  AST_PTR_HIGH: assert property (@(posedge clock) disable iff (rst)
    (enable && pointer_high_write)
    |=> data_pointer_16[15:8] == $past(reg_wdata))
    else $error("Pointer high byte not written");
  AST_FLASH: assert property (@(posedge clock) disable iff (rst)
    (enable && state == st_idle && req && req_write
     && program_store_write_enable) |=> flash_write)
    else $error("Flash write not steered");
  AST_MUX_ALE: assert property (@(posedge clock) disable iff (rst)
    $rose(port_claim)
    |-> port_addr_latch == !external_memory_config[`CFG_MUX_BIT])
    else $error("Address latch wrong for mux mode");

endmodule : xdata_map

// File: core/xdata_map_defines.svh
// Constants for the external data address map and port claim block.
// Assumes inclusion by bare name from core/ files only.
`ifndef XDATA_MAP_DEFINES_SVH
`define XDATA_MAP_DEFINES_SVH

// Configuration byte field positions and register reset values
`define CFG_FIFO_WIN_BIT   6
`define CFG_MUX_BIT        4
`define CFG_MODE_HI        3
`define CFG_MODE_LO        2
`define CFG_RESET          8'h03
`define PAGE_RESET         8'h00
`define POINTER_RESET      16'h0000

// Address windows
`define FIFO_WIN_LO        16'h0400
`define FIFO_WIN_HI        16'h07ff
`define FIFO_INDEX_W       10
`define ONCHIP_4K_BYTES    16'h1000
`define ONCHIP_2K_BYTES    16'h0800
`define ONCHIP_ADDR_W      12

// FIFO accesses wait this many system clocks for the USB domain
`define FIFO_WAIT_CYCLES   4'h3

`endif

// File: core/xdata_map_pkg.sv
// Types for the external data address map block.
// Assumes nothing beyond a SystemVerilog compiler.
package xdata_map_pkg;

  // Memory mode selected by the configuration byte
  typedef enum logic [1:0] {
    mode_onchip_only,
    mode_split_nobank,
    mode_split_bank,
    mode_offchip_only
  } mem_mode_e;

  // Target of one external move access
  typedef enum logic [1:0] {
    target_onchip,
    target_fifo,
    target_offchip,
    target_flash
  } target_e;

endpackage : xdata_map_pkg

// File: core/xdata_ram.sv
// Byte-wide single-port RAM with registered read data.
// Assumes one synchronous clock and a clock enable from the parent.
`timescale 1ns/1ps
module xdata_ram #(
  parameter int ADDR_W = 12
) (
  // Clock
  input  wire logic              clock,
  input  wire logic              enable,
  // Access
  input  wire logic              select,
  input  wire logic              write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata
);

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Write on select, read data registered
  always_ff @(posedge clock) begin
    if (enable && select) begin
      if (write) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule : xdata_ram

// File: tb/offchip_mem.sv
// Behavioural off-chip byte memory on the external memory port pins.
// Assumes the port strobes are registered on the rising system clock.
`timescale 1ns/1ps
module offchip_mem (
  // Clock
  input  wire logic        clock,
  // Pins driven by the memory port
  input  wire logic        port_claim,
  input  wire logic [15:0] port_addr,
  input  wire logic [7:0]  port_data_out,
  input  wire logic        port_data_oe,
  input  wire logic        port_read_strobe_n,
  input  wire logic        port_write_strobe_n,
  // Data lines back toward the port
  output logic      [7:0]  port_data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;

  // Store driven data on write strobe, remember last driven byte
  always @(posedge clock) begin
    if (port_claim && port_data_oe && !port_write_strobe_n) begin
      mem[port_addr] <= port_data_out;
    end
    if (!port_read_strobe_n) last <= port_data_in;
  end

  // Drive only inside the read strobe, else a changing pattern
  assign port_data_in = (port_claim && !port_read_strobe_n) ?
                        mem[port_addr] : ~last;
endmodule : offchip_mem

// File: tb/testbench.sv
// Self-checking bench for the external data map and port claim block.
// Assumes the off-chip model beside it and a FIFO responder here.
`timescale 1ns/1ps
module testbench;
  import xdata_map_pkg::*;
  logic clock = 1'b0, rst = 1'b1, enable = 1'b1;
  logic pointer_high_write = 1'b0, pointer_low_write = 1'b0;
  logic page_write = 1'b0, config_write = 1'b0, small_ram = 1'b0;
  logic program_store_write_enable = 1'b0, req = 1'b0, req_write = 1'b0;
  logic short_form = 1'b0, use_pointer_one = 1'b0, fifo_ack = 1'b0;
  logic [7:0] reg_wdata = 8'h00, wdata = 8'h00, fifo_rdata = 8'h00;
  logic [7:0] indirect_pointer_zero = 8'h00, indirect_pointer_one = 8'h00;
  logic done, flash_write, fifo_req, fifo_write, port_claim;
  logic port_addr_high_oe, port_data_oe, port_read_strobe_n;
  logic port_write_strobe_n, port_addr_latch;
  logic [7:0] rdata, fifo_wdata, port_data_in, port_data_out;
  logic [7:0] external_data_space_page_select, external_memory_config, got, d, x;
  logic [15:0] flash_addr, port_addr, data_pointer_16, a, claim_a, flash_a;
  logic [9:0] fifo_addr, fifo_a;
  logic [7:0] fifo_mem [0:1023];
  logic claim_seen, fifo_seen, flash_seen, oe_bad, hi_oe, ale_seen;
  logic [31:0] lfsr = 32'h0000dbfd;
  int mismatches = 0, checks_done = 0, cyc;

  xdata_map DUT (.clock, .rst, .enable, .pointer_high_write,
    .pointer_low_write, .page_write, .config_write, .reg_wdata,
    .indirect_pointer_zero, .indirect_pointer_one,
    .program_store_write_enable, .small_ram, .req, .req_write, .short_form,
    .use_pointer_one, .wdata, .done, .rdata, .flash_write, .flash_addr,
    .fifo_req, .fifo_write, .fifo_addr, .fifo_wdata, .fifo_ack, .fifo_rdata,
    .port_data_in, .port_claim, .port_addr, .port_addr_high_oe,
    .port_data_out, .port_data_oe, .port_read_strobe_n,
    .port_write_strobe_n, .port_addr_latch, .data_pointer_16,
    .external_data_space_page_select, .external_memory_config);

  offchip_mem mem (.clock, .port_claim, .port_addr, .port_data_out,
    .port_data_oe, .port_read_strobe_n, .port_write_strobe_n, .port_data_in);

  // Clock at 200 MHz
  always #2.5 clock = ~clock;

  // Monitor pins and answer FIFO requests on the falling edge
  always @(negedge clock) begin
    if (port_claim === 1'b1) begin
      claim_seen = 1'b1;
      claim_a = port_addr;
      hi_oe = port_addr_high_oe;
    end
    if (port_addr_latch === 1'b1) ale_seen = 1'b1;
    if (port_read_strobe_n === 1'b0 && port_data_oe !== 1'b0) oe_bad = 1'b1;
    if (flash_write === 1'b1) begin
      flash_seen = 1'b1;
      flash_a = flash_addr;
    end
    if (fifo_req === 1'b1 && !fifo_ack) begin
      fifo_seen = 1'b1;
      fifo_a = fifo_addr;
      if (fifo_write) fifo_mem[fifo_addr] = fifo_wdata;
      fifo_rdata <= fifo_mem[fifo_addr];
    end else fifo_rdata <= ~fifo_rdata;
    fifo_ack <= (fifo_req === 1'b1) && !fifo_ack;
  end

  function logic [7:0] rnd();
    for (int i = 0; i < 8; i++)
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  // Expected configuration byte, bits 7 and 5 read zero
  function logic [7:0] cfg(input logic f, m, input mem_mode_e md);
    return {1'b0, f, 1'b0, m, md, 2'b11};
  endfunction : cfg

  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One register strobe: 0 high, 1 low, 2 page, 3 config
  task wreg(input int w, input logic [7:0] v);
    @(negedge clock);
    pointer_high_write = (w == 0);
    pointer_low_write = (w == 1);
    page_write = (w == 2);
    config_write = (w == 3);
    reg_wdata = v;
    @(negedge clock);
    {pointer_high_write, pointer_low_write, page_write, config_write} = 4'h0;
  endtask : wreg

  // Set up pointers, run one access and wait for done
  task acc(input logic wr, sf, p1, input logic [15:0] ad, input logic [7:0] v);
    if (sf) begin
      wreg(2, ad[15:8]);
      indirect_pointer_zero = p1 ? ~ad[7:0] : ad[7:0];
      indirect_pointer_one = p1 ? ad[7:0] : ~ad[7:0];
    end else begin
      wreg(0, ad[15:8]);
      wreg(1, ad[7:0]);
    end
    {claim_seen, fifo_seen, flash_seen, oe_bad, ale_seen, hi_oe} = 6'h00;
    @(negedge clock);
    {req, req_write, short_form, use_pointer_one, wdata} =
      {1'b1, wr, sf, p1, v};
    cyc = 0;
    while (done !== 1'b1 && cyc < 60) begin
      @(posedge clock);
      #1 cyc++;
    end
    got = rdata;
    @(negedge clock);
    req = 1'b0;
    @(negedge clock);
    if (cyc >= 60) begin
      mismatches++;
      complete_run();
    end
  endtask : acc

  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    check(external_memory_config, 16'h0003);
    check(data_pointer_16, 16'h0000);
    repeat (4) begin
      d = rnd();
      x = rnd();
      wreg(0, d);
      wreg(1, x);
      check(data_pointer_16, {d, x});
    end
    wreg(3, cfg(1, 1, mode_split_bank) | 8'ha0);
    check(external_memory_config, cfg(1, 1, mode_split_bank));
    // Mid-run reset, then a write while the clock enable is low
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    check(data_pointer_16, 16'h0000);
    check(external_memory_config, 16'h0003);
    enable = 1'b0;
    wreg(2, 8'h77);
    check(external_data_space_page_select, 16'h0000);
    enable = 1'b1;
    wreg(2, 8'h77);
    check(external_data_space_page_select, 16'h0077);
    $display("test registers done");
    // On-chip write, aliased short-form read, both RAM sizes
    wreg(3, cfg(0, 0, mode_onchip_only));
    for (int s = 0; s < 2; s++) begin
      small_ram = s;
      d = rnd();
      a = {5'h00, d[2:0], rnd()};
      d = rnd();
      acc(1, 0, 0, a, d);
      check(cyc, 2);
      check(flash_seen, 0);
      acc(0, 1, s, a + (s ? 16'h0800 : 16'h1000), 8'h00);
      check(got, d);
      check(claim_seen, 0);
    end
    $display("test onchip done");
    // FIFO window hides on-chip RAM only while enabled
    x = rnd();
    acc(1, 0, 0, 16'h0400, x);
    check(fifo_seen, 0);
    wreg(3, cfg(1, 0, mode_onchip_only));
    for (int i = 0; i < 2; i++) begin
      a = i ? 16'h07ff : 16'h0400;
      d = rnd();
      acc(1, 0, 0, a, d);
      check(fifo_a, a[9:0]);
      acc(0, 0, 0, a, 8'h00);
      check(got, d);
      check(cyc >= 5, 1);
      check(claim_seen, 0);
    end
    acc(0, 0, 0, 16'h0800, 8'h00);
    check(fifo_seen, 0);
    wreg(3, cfg(0, 0, mode_onchip_only));
    acc(0, 0, 0, 16'h0400, 8'h00);
    check(got, x);
    $display("test fifo done");
    // Off-chip in both bus modes
    for (int m = 0; m < 2; m++) begin
      wreg(3, cfg(0, m, mode_offchip_only));
      a = {rnd(), rnd()};
      d = rnd();
      acc(1, 0, 0, a, d);
      check(claim_a, a);
      check(port_claim, 0);
      acc(0, 0, 0, a, 8'h00);
      check(got, d);
      check(oe_bad, 0);
      check(claim_seen, 1);
      if (m == 0) check(cyc, 3);
      check(ale_seen, m == 0);
      check(hi_oe, 1);
    end
    wreg(3, cfg(0, 1, mode_split_bank));
    small_ram = 1'b0;
    d = rnd();
    acc(1, 1, 1, 16'h1234, d);
    check(claim_a, 16'h1234);
    acc(0, 0, 0, 16'h1234, 8'h00);
    check(got, d);
    acc(1, 0, 0, 16'h0100, d);
    check(claim_seen, 0);
    wreg(3, cfg(0, 1, mode_split_nobank));
    acc(0, 0, 0, 16'h2345, 8'h00);
    check(claim_a, 16'h2345);
    check(hi_oe, 1);
    acc(0, 1, 0, 16'h2345, 8'h00);
    check(hi_oe, 0);
    $display("test offchip done");
    // Flash steering of writes only
    program_store_write_enable = 1'b1;
    a = {rnd(), rnd()};
    acc(1, 0, 0, a, rnd());
    check(flash_seen, 1);
    check(flash_a, a);
    check(claim_seen, 0);
    acc(0, 0, 0, a, 8'h00);
    check(flash_seen, 0);
    $display("test flash done");
    complete_run();
  end
endmodule : testbench
